// [rtl/jpl_port.sv]
// dual joystick port: decode, configuration, status and four axis timers
`timescale 1ns/10ps
`include "jpl_params.svh"
module jpl_port (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire jpl_pkg::jpl_io_req_t io_req_i,
  output logic [7:0] io_rdata_o,
  input wire jpl_pkg::jpl_cfg_req_t cfg_req_i,
  output logic [7:0] cfg_rdata_o,
  output logic joystick_read_strobe_o,
  output logic joystick_write_strobe_o,
  input wire jpl_pkg::jpl_buttons_t buttons_i,
  input wire logic [3:0] rc_trip_i,
  input wire logic [3:0] rc_timing_pin_i,
  output logic [3:0] rc_timing_pin_o,
  output logic [3:0] rc_timing_pin_oe_o,
  output logic stick1_x_timer_o,
  output logic stick1_y_timer_o,
  output logic stick2_x_timer_o,
  output logic stick2_y_timer_o,
  output logic game_power_o
);

  // ==========================================================================
  // configuration storage
  logic [7:0] base_high_reg;
  logic [7:0] base_high_next;
  logic [7:0] base_low_reg;
  logic [7:0] base_low_next;
  logic activate_reg;
  logic activate_next;
  logic [7:0] power_ctrl_reg;
  logic [7:0] power_ctrl_next;

  // ==========================================================================
  // decode wires
  wire cfg_hit_high;
  wire cfg_hit_low;
  wire cfg_hit_act;
  wire cfg_hit_pwr;
  wire [15:0] base_addr;
  wire addr_match;
  wire read_hit;
  wire write_hit;

  // ==========================================================================
  // status and timer wires
  logic write_prev_reg;
  wire write_done;
  logic [3:0] axis_out;
  logic [7:0] status_reg;
  wire [7:0] status_next;
  logic [7:0] io_rdata_reg;
  wire [7:0] io_rdata_next;
  logic [7:0] cfg_rdata_reg;
  logic [7:0] cfg_rdata_next;
  logic [7:0] power_view;

  // ==========================================================================
  // configuration index decode
  assign cfg_hit_high = (cfg_req_i.index == `JPL_CFG_BASE_HIGH);
  assign cfg_hit_low = (cfg_req_i.index == `JPL_CFG_BASE_LOW);
  assign cfg_hit_act = (cfg_req_i.index == `JPL_CFG_ACTIVATE);
  assign cfg_hit_pwr = (cfg_req_i.index == `JPL_CFG_POWER_CTRL);

  always_comb begin
    base_high_next = base_high_reg;
    base_low_next = base_low_reg;
    if (cfg_req_i.wr && cfg_hit_high) begin
      base_high_next = cfg_req_i.wdata;
    end
    if (cfg_req_i.wr && cfg_hit_low) begin
      base_low_next = cfg_req_i.wdata;
    end
  end

  // one flop holds both views of the game port power/activate bit
  always_comb begin
    activate_next = activate_reg;
    power_ctrl_next = power_ctrl_reg;
    if (cfg_req_i.wr && cfg_hit_act) begin
      activate_next = cfg_req_i.wdata[`JPL_ACTIVATE_BIT];
    end
    if (cfg_req_i.wr && cfg_hit_pwr) begin
      power_ctrl_next = cfg_req_i.wdata;
      activate_next = cfg_req_i.wdata[`JPL_POWER_GAME_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      base_high_reg <= `JPL_BASE_RESET;
      base_low_reg <= `JPL_BASE_RESET;
      activate_reg <= 1'b0;
      power_ctrl_reg <= `JPL_POWER_RESET;
    end else begin
      base_high_reg <= base_high_next;
      base_low_reg <= base_low_next;
      activate_reg <= activate_next;
      power_ctrl_reg <= power_ctrl_next;
    end
  end

  // power control reads back with bit 2 taken from the shared bit
  always_comb begin
    power_view = power_ctrl_reg;
    power_view[`JPL_POWER_GAME_BIT] = activate_reg;
  end

  // ==========================================================================
  // configuration read-back
  always_comb begin
    cfg_rdata_next = cfg_rdata_reg;
    if (cfg_req_i.rd) begin
      cfg_rdata_next = 8'h00;
      if (cfg_hit_high) begin
        cfg_rdata_next = base_high_reg;
      end else if (cfg_hit_low) begin
        cfg_rdata_next = base_low_reg;
      end else if (cfg_hit_act) begin
        cfg_rdata_next = {7'h00, activate_reg};
      end else if (cfg_hit_pwr) begin
        cfg_rdata_next = power_view;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cfg_rdata_reg <= 8'h00;
    end else begin
      cfg_rdata_reg <= cfg_rdata_next;
    end
  end

  assign cfg_rdata_o = cfg_rdata_reg;
  assign game_power_o = activate_reg;

  // ==========================================================================
  // I/O address decode
  assign base_addr = {base_high_reg, base_low_reg};
  assign addr_match = (io_req_i.addr == (base_addr + `JPL_STATUS_OFFSET));
  assign read_hit = activate_reg && addr_match && io_req_i.rd;
  assign write_hit = activate_reg && addr_match && io_req_i.wr;
  assign joystick_read_strobe_o = read_hit;
  assign joystick_write_strobe_o = write_hit;

  // ==========================================================================
  // trailing edge of the write strobe
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      write_prev_reg <= 1'b0;
    end else begin
      write_prev_reg <= write_hit;
    end
  end

  assign write_done = write_prev_reg && !write_hit;

  // ==========================================================================
  // axis timers, bit order stick1 X, stick1 Y, stick2 X, stick2 Y
  genvar g;
  generate
    for (g = 0; g < `JPL_AXIS_COUNT; g = g + 1) begin : gen_axis
      jpl_axis_timer u_axis (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .write_active_i(write_hit),
        .write_done_i(write_done),
        .trip_i(rc_trip_i[g]),
        .axis_timer_out_o(axis_out[g]),
        .rc_timing_pin_o(rc_timing_pin_o[g]),
        .rc_timing_pin_oe_o(rc_timing_pin_oe_o[g])
      );
    end
  endgenerate

  assign stick1_x_timer_o = axis_out[0];
  assign stick1_y_timer_o = axis_out[1];
  assign stick2_x_timer_o = axis_out[2];
  assign stick2_y_timer_o = axis_out[3];

  // ==========================================================================
  // status byte, write data is never stored here
  assign status_next = {buttons_i.stick2_button2,
                        buttons_i.stick2_button1,
                        buttons_i.stick1_button2,
                        buttons_i.stick1_button1,
                        axis_out[3],
                        axis_out[2],
                        axis_out[1],
                        axis_out[0]};

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      status_reg <= `JPL_STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // read data is captured while the read strobe is active
  assign io_rdata_next = read_hit ? status_reg : io_rdata_reg;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      io_rdata_reg <= `JPL_STATUS_RESET;
    end else begin
      io_rdata_reg <= io_rdata_next;
    end
  end

  assign io_rdata_o = io_rdata_reg;

endmodule

// [inc/jpl_params.svh]
// constants for the dual joystick port logic
// Notes on behaviour
// - each joystick has X and Y timer channels with RC inputs plus two buttons
// - any I/O write to the base restarts the axes by pulling RC pins low
// - the restart takes effect when the write strobe returns to inactive
// - at the two-thirds trip the timer output clears and the pin discharges
// - status sits at base plus zero, eight bits, zero after power-on reset
// - bits 7..4 stick2 b2,b1, stick1 b2,b1; bits 3..0 stick2 Y,X, stick1 Y,X
// - status is read-only; write data is dropped and only triggers a restart
// - read strobe fires for an I/O read at the programmed base address
// - write strobe fires for an I/O write at the programmed base address
// - config index joystick_base_high gives the upper base byte, joystick_base_low the lower byte
// - with activate cleared the base is not decoded and no strobes occur
// - power control bit 2 and the activate bit are one shared bit
`ifndef JPL_PARAMS_SVH
`define JPL_PARAMS_SVH

// ==========================================================================
// register locations
`define JPL_STATUS_OFFSET 16'h0000
`define JPL_CFG_BASE_HIGH 8'h60
`define JPL_CFG_BASE_LOW 8'h61
`define JPL_CFG_ACTIVATE 8'h30
`define JPL_CFG_POWER_CTRL 8'h22

// ==========================================================================
// field positions and reset values
`define JPL_POWER_GAME_BIT 2
`define JPL_ACTIVATE_BIT 0
`define JPL_STATUS_RESET 8'h00
`define JPL_BASE_RESET 8'h00
`define JPL_POWER_RESET 8'h00
`define JPL_AXIS_COUNT 4

`endif

// [inc/jpl_pkg.sv]
// types shared by the dual joystick port logic
package jpl_pkg;

  // ==========================================================================
  // host I/O cycle
  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } jpl_io_req_t;

  // ==========================================================================
  // configuration index cycle
  typedef struct packed {
    logic [7:0] index;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } jpl_cfg_req_t;

  // ==========================================================================
  // button levels of both sticks
  typedef struct packed {
    logic stick2_button2;
    logic stick2_button1;
    logic stick1_button2;
    logic stick1_button1;
  } jpl_buttons_t;

  // ==========================================================================
  // one axis timer
  typedef enum logic [1:0] {
    JPL_DISCHARGE,
    JPL_RESTART,
    JPL_CHARGE
  } jpl_axis_state_t;

endpackage

// [rtl/jpl_axis_timer.sv]
// one axis timer channel with its RC timing pin
`timescale 1ns/10ps
module jpl_axis_timer (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic write_active_i,
  input wire logic write_done_i,
  input wire logic trip_i,
  output logic axis_timer_out_o,
  output logic rc_timing_pin_o,
  output logic rc_timing_pin_oe_o
);

  jpl_pkg::jpl_axis_state_t state_reg;
  jpl_pkg::jpl_axis_state_t state_next;

  // ==========================================================================
  // sequence
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      jpl_pkg::JPL_DISCHARGE: begin
        if (write_active_i) begin
          state_next = jpl_pkg::JPL_RESTART;
        end
      end
      jpl_pkg::JPL_RESTART: begin
        if (write_done_i) begin
          state_next = jpl_pkg::JPL_CHARGE;
        end
      end
      jpl_pkg::JPL_CHARGE: begin
        if (write_active_i) begin
          state_next = jpl_pkg::JPL_RESTART;
        end else if (trip_i) begin
          state_next = jpl_pkg::JPL_DISCHARGE;
        end
      end
      default: begin
        state_next = jpl_pkg::JPL_DISCHARGE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_reg <= jpl_pkg::JPL_DISCHARGE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // pins: the pin is held low except while the cap charges
  assign axis_timer_out_o = (state_reg == jpl_pkg::JPL_CHARGE);
  assign rc_timing_pin_o = 1'b0;
  assign rc_timing_pin_oe_o = (state_reg != jpl_pkg::JPL_CHARGE);

endmodule

// [test/jpl_rc_model.sv]
// RC timing networks of both joysticks, tripping after a set charge time
`timescale 1ns/10ps
module jpl_rc_model (
  input wire logic clk_i,
  input wire logic [3:0] oe_i,
  input wire logic [31:0] dly_i,
  output logic [3:0] trip_o,
  output logic [3:0] pin_o
);
  // ==========================================
  // charge counters, cleared while the pin is held low
  int cnt [4];
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 4; i++) begin
      cnt[i] <= oe_i[i] ? 0 : cnt[i] + 1;
    end
  end
  for (genvar g = 0; g < 4; g++) begin : g_ax
    assign trip_o[g] = !oe_i[g] && (cnt[g] >= dly_i[8*g +: 8]);
  end
  assign pin_o = ~oe_i & trip_o;
endmodule

// [test/jpl_port_assertions.sv]
// assertion checker for the joystick port
`timescale 1ns/10ps
module jpl_port_assertions (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire jpl_pkg::jpl_io_req_t io_req_i,
  input wire logic [7:0] io_rdata_o,
  input wire jpl_pkg::jpl_cfg_req_t cfg_req_i,
  input wire logic joystick_read_strobe_o,
  input wire logic joystick_write_strobe_o,
  input wire logic [3:0] rc_trip_i,
  input wire logic [3:0] rc_timing_pin_o,
  input wire logic [3:0] rc_timing_pin_oe_o,
  input wire logic stick1_x_timer_o,
  input wire logic stick2_x_timer_o,
  input wire logic stick2_y_timer_o,
  input wire logic game_power_o
);
  // ==========================================
  // properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  chk_reset_values: assert property ($rose(rstn_i) |-> rc_timing_pin_oe_o == 4'hf
    && io_rdata_o == 8'h00 && !game_power_o) else $error("bad reset state");
  chk_gate_off: assert property (!game_power_o |-> !joystick_read_strobe_o
    && !joystick_write_strobe_o) else $error("strobe while inactive");
  chk_read_strobe: assert property (joystick_read_strobe_o |-> io_req_i.rd)
    else $error("read strobe without read");
  chk_write_strobe: assert property (joystick_write_strobe_o |-> io_req_i.wr)
    else $error("write strobe without write");
  chk_write_restart: assert property (joystick_write_strobe_o |=> rc_timing_pin_oe_o == 4'hf
    && !stick1_x_timer_o && !stick2_y_timer_o) else $error("no restart on write");
  chk_back_edge: assert property ($fell(joystick_write_strobe_o) |=> rc_timing_pin_oe_o == 4'h0
    && stick1_x_timer_o) else $error("charge not started on back edge");
  chk_trip_clear: assert property (stick1_x_timer_o && rc_trip_i[0] && !joystick_write_strobe_o
    |=> !stick1_x_timer_o && rc_timing_pin_oe_o[0]) else $error("trip ignored");
  chk_axis_hold: assert property (stick2_x_timer_o && !rc_trip_i[2] && !joystick_write_strobe_o
    |=> stick2_x_timer_o) else $error("axis dropped early");
  chk_pin_drive: assert property (rc_timing_pin_o == 4'h0
    && !(stick2_y_timer_o && rc_timing_pin_oe_o[3])) else $error("pin drive wrong");
  chk_power_mirror: assert property (cfg_req_i.wr && cfg_req_i.index == 8'h22
    |=> game_power_o == $past(cfg_req_i.wdata[2])) else $error("power bit lost");
  chk_activate_mirror: assert property (cfg_req_i.wr && cfg_req_i.index == 8'h30
    |=> game_power_o == $past(cfg_req_i.wdata[0])) else $error("activate lost");
  cov_write: cover property (joystick_write_strobe_o ##1 !joystick_write_strobe_o);
  cov_trip: cover property (stick1_x_timer_o && rc_trip_i[0]);
  cov_read: cover property (joystick_read_strobe_o);
endmodule
bind jpl_port jpl_port_assertions u_chk (.clk_i, .rstn_i, .io_req_i, .io_rdata_o, .cfg_req_i,
  .joystick_read_strobe_o, .joystick_write_strobe_o, .rc_trip_i, .rc_timing_pin_o,
  .rc_timing_pin_oe_o, .stick1_x_timer_o, .stick2_x_timer_o, .stick2_y_timer_o, .game_power_o);

// [test/jpl_port_tb.sv]
// self-checking bench for the dual joystick port
`timescale 1ns/10ps
module jpl_port_tb;
  logic clk_i, rstn_i, rstb, wstb, pwr, hit;
  jpl_pkg::jpl_io_req_t io_req;
  jpl_pkg::jpl_cfg_req_t cfg_req;
  jpl_pkg::jpl_buttons_t btn;
  logic [7:0] io_rdata, cfg_rdata, q;
  logic [3:0] trip, pin, pin_o, oe, tm;
  logic [31:0] dly;
  logic [15:0] base;
  int errors, cmp_count, cyc, t0, e, d;
  jpl_port DUT (.clk_i(clk_i), .rstn_i(rstn_i), .io_req_i(io_req), .io_rdata_o(io_rdata),
    .cfg_req_i(cfg_req), .cfg_rdata_o(cfg_rdata), .joystick_read_strobe_o(rstb),
    .joystick_write_strobe_o(wstb), .buttons_i(btn), .rc_trip_i(trip), .rc_timing_pin_i(pin),
    .rc_timing_pin_o(pin_o), .rc_timing_pin_oe_o(oe), .stick1_x_timer_o(tm[0]),
    .stick1_y_timer_o(tm[1]), .stick2_x_timer_o(tm[2]), .stick2_y_timer_o(tm[3]),
    .game_power_o(pwr));
  jpl_rc_model PART (.clk_i(clk_i), .oe_i(oe), .dly_i(dly), .trip_o(trip), .pin_o(pin));
  // ==========================================
  // tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cfg(input logic [7:0] ix, input logic w, input logic [7:0] dat);
    @(negedge clk_i);
    cfg_req = '{index: ix, rd: !w, wr: w, wdata: dat};
    @(negedge clk_i);
    cfg_req = '0;
    @(posedge clk_i);
    #1 q = cfg_rdata;
  endtask
  task automatic io(input logic [15:0] a, input logic w, input logic [7:0] dat);
    @(negedge clk_i);
    io_req = '{addr: a, rd: !w, wr: w, wdata: dat};
    #1 hit = w ? wstb : rstb;
    @(negedge clk_i);
    io_req = '0;
    @(posedge clk_i);
    #1 q = io_rdata;
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ==========================================
  // clock, watchdog, tests
  initial begin
    clk_i = 0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc++;
  initial begin
    #200000;
    errors++;
    results();
  end
  initial begin
    rstn_i = 0;
    io_req = '0;
    cfg_req = '0;
    btn = '0;
    dly = '0;
    d = $urandom(30);
    repeat (10) @(posedge clk_i);
    @(negedge clk_i) rstn_i = 1;
    chk(io_rdata, 8'h00);
    chk({4'h0, oe}, 8'h0f);
    base = 16'($urandom) | 16'h0100;
    cfg(8'h60, 1, base[15:8]);
    cfg(8'h61, 1, base[7:0]);
    cfg(8'h60, 0, 8'h00);
    chk(q, base[15:8]);
    cfg(8'h61, 0, 8'h00);
    chk(q, base[7:0]);
    cfg(8'h55, 0, 8'h00);
    chk(q, 8'h00);
    io(base, 1, 8'h00);
    chk({7'h0, hit}, 8'h00);
    chk({tm, oe}, 8'h0f);
    cfg(8'h22, 1, 8'h04);
    cfg(8'h30, 0, 8'h00);
    chk({6'h0, q[0], pwr}, 8'h03);
    io(base + 16'h1, 0, 8'h00);
    chk({7'h0, hit}, 8'h00);
    io(base, 0, 8'h00);
    chk({7'h0, hit}, 8'h01);
    $display("test config done");
    for (int r = 0; r < 4; r++) begin
      @(negedge clk_i);
      dly = $urandom | 32'h14141414;
      btn = 4'($urandom);
      io(base, 1, 8'($urandom));
      chk({7'h0, hit}, 8'h01);
      chk({tm, oe}, 8'hf0);
      t0 = cyc;
      // the status byte lags the timers, so the first poll starts one cycle later
      @(negedge clk_i);
      for (int p = 0; p < 160; p++) begin
        io(base, 0, 8'h00);
        e = cyc - t0;
        for (int i = 0; i < 4; i++) begin
          d = dly[8*i +: 8];
          if (e < d || e > d + 8) chk({7'h0, q[i]}, {7'h0, e < d + 4});
        end
        chk({q[7:4], 4'h0}, {btn, 4'h0});
        if (q[3:0] === 4'h0) break;
      end
      chk({4'h0, q[3:0]}, 8'h00);
      chk({tm, oe}, 8'h0f);
      chk({4'h0, pin_o}, 8'h00);
      $display("test measurement %0d done", r);
    end
    cfg(8'h30, 1, 8'h00);
    chk({7'h0, pwr}, 8'h00);
    io(base, 0, 8'h00);
    chk({7'h0, hit}, 8'h00);
    $display("test deactivate done");
    results();
  end
endmodule
